// ===== logic/orr_pkg.sv
// Package: register map, field layout and reset values for overcurrent report
package orr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MSG_LOW = 8'h06;
  localparam logic [7:0] IDX_MSG_HIGH = 8'h07;
  localparam logic [7:0] IDX_LIVE_LOW = 8'h08;
  localparam logic [7:0] IDX_LIVE_HIGH = 8'h09;
  localparam logic [7:0] IDX_CONV_UPPER = 8'h0a;
  localparam logic [7:0] IDX_CONV_LOWER = 8'h0b;
  localparam logic [7:0] IDX_OC_EN_LOW = 8'h12;
  localparam logic [7:0] IDX_OC_EN_HIGH = 8'h13;
  localparam logic [7:0] IDX_IO_MODE = 8'h20;
  localparam logic [7:0] IDX_EOI = 8'h21;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h22;
  localparam logic [7:0] IDX_EVT_MASK = 8'h23;
  localparam logic [7:0] IDX_CONV_CFG = 8'h24;

  // Address decode field: word index sits above the byte offset
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CHAN = 16'h0000;
  localparam logic [9:0] RST_CONV = 10'h000;
  localparam logic [3:0] RST_IO_MODE = 4'h0;
  localparam logic [2:0] RST_EVT = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Conversion result layout
  localparam int CONV_UPPER_MSB = 9;
  localparam int CONV_UPPER_LSB = 2;
  localparam int CONV_LOWER_POS = 6;

  // Event status bit positions
  localparam int EVT_NEW_MSG = 0;
  localparam int EVT_TRAPPED = 1;
  localparam int EVT_CONV_DONE = 2;
  localparam int EVT_BITS = 3;

  // Channels per mode block
  localparam int BLOCK_CH = 4;

  // Lock state of the message registers
  typedef enum logic [1:0] {
    ORR_OPEN = 2'b01,
    ORR_LOCKED = 2'b10
  } orr_lock_t;

endpackage

// ===== logic/orr_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module orr_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// ===== logic/orr_top.sv
// Overcurrent report, live status and conversion result registers on APB
//
// Behaviour
// R1: Reading a message register while an interrupt is active locks messages until end of interrupt.
// R2: Overcurrent events arising while locked are kept in a pending pipeline.
// R3: End of interrupt with pending events leaves the interrupt pin asserted.
// R4: End of interrupt with pending events reloads the messages from the pipeline.
// R5: A channel latches its message bit on entering overcurrent only when enabled.
// R6: Channels in input mode read zero in the message registers.
// R7: Disabling then re-enabling a channel's enable while the messages are not locked clears its message bit.
// R8: Live status shows the present overcurrent and never raises an interrupt.
// R9: Live status reads zero for input channels and one for an active overcurrent.
// R10: The conversion result is shown in two read-only registers.
// R11: Converter source and reference come from a separate configuration word.
// R12: Result bits 9..2 go in the upper register, bits 1..0 in bits 7..6 of the lower.
`timescale 1ns/1ps
module orr_top #(
  parameter int CHANNELS = 16,
  parameter int OTHER_IRQS = 7,
  parameter int CONV_WIDTH = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Output stage overcurrent pins, asynchronous
  input wire logic [CHANNELS-1:0] oc_live_pin_i,
  // Other interrupt flags of the device
  input wire logic [OTHER_IRQS-1:0] other_irq_flags_i,
  // Converter result
  input wire logic [CONV_WIDTH-1:0] conv_result_i,
  input wire logic conv_done_i,
  // Configuration and interrupts out
  output logic [7:0] conv_config_o,
  output logic [CHANNELS/orr_pkg::BLOCK_CH-1:0] io_input_mode_o,
  output logic irq_pin_n_o,
  output logic irq_o
);

  localparam int BLOCKS = CHANNELS / orr_pkg::BLOCK_CH;

  orr_pkg::orr_lock_t lock_reg;
  orr_pkg::orr_lock_t lock_next;
  logic [CHANNELS-1:0] oc_sync;
  logic [CHANNELS-1:0] oc_prev_reg;
  logic [CHANNELS-1:0] in_mode_ch;
  logic [CHANNELS-1:0] oc_live_vec;
  logic [CHANNELS-1:0] overcurrent_irq_enable;
  logic [CHANNELS-1:0] en_prev_reg;
  logic [CHANNELS-1:0] en_rise;
  logic [CHANNELS-1:0] rise_vec;
  logic [CHANNELS-1:0] msg_reg;
  logic [CHANNELS-1:0] msg_next;
  logic [CHANNELS-1:0] pend_reg;
  logic [CHANNELS-1:0] pend_next;
  logic [CONV_WIDTH-1:0] conv_reg;
  logic [orr_pkg::EVT_BITS-1:0] evt_reg;
  logic [orr_pkg::EVT_BITS-1:0] evt_set;
  logic [orr_pkg::EVT_BITS-1:0] mask_reg;
  logic [7:0] idx;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic end_of_interrupt_reset;
  logic irq_active;
  logic locked;
  logic [31:0] rdata_next;
  logic mapped;

  // Overcurrent pins cross into the clock domain
  orr_sync #(
    .WIDTH(CHANNELS)
  ) u_oc_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .async_i(oc_live_pin_i),
    .sync_o(oc_sync)
  );

  // Bus phase decode
  assign idx = paddr_i[orr_pkg::ADDR_IDX_MSB:orr_pkg::ADDR_IDX_LSB];
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_o;
  assign wr_acc = access && pwrite_i;
  assign rd_acc = access && !pwrite_i;
  assign end_of_interrupt_reset = wr_acc && (idx == orr_pkg::IDX_EOI);
  assign locked = (lock_reg == orr_pkg::ORR_LOCKED);

  // Per-channel mode and live view
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    assign in_mode_ch[g] = io_input_mode_o[g / orr_pkg::BLOCK_CH];
    assign oc_live_vec[g] = oc_sync[g] & ~in_mode_ch[g]; // R9
    assign rise_vec[g] = oc_live_vec[g] & ~oc_prev_reg[g]
                         & overcurrent_irq_enable[g]; // R5
    assign en_rise[g] = overcurrent_irq_enable[g] & ~en_prev_reg[g]; // R7
  end

  // Any interrupt pin source active: messages, pending or other flags
  assign irq_active = (|msg_reg) || (|pend_reg) || (|other_irq_flags_i);

  // Edge history of pins and enables
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      oc_prev_reg <= orr_pkg::RST_CHAN;
      en_prev_reg <= orr_pkg::RST_CHAN;
    end else begin
      oc_prev_reg <= oc_live_vec;
      en_prev_reg <= overcurrent_irq_enable;
    end
  end

  // Lock state
  always_comb begin
    lock_next = lock_reg;
    unique case (lock_reg)
      orr_pkg::ORR_OPEN: begin
        if (rd_acc && irq_active && (idx == orr_pkg::IDX_MSG_LOW ||
            idx == orr_pkg::IDX_MSG_HIGH)) begin
          lock_next = orr_pkg::ORR_LOCKED; // R1
        end
      end
      orr_pkg::ORR_LOCKED: begin
        if (end_of_interrupt_reset) begin
          lock_next = orr_pkg::ORR_OPEN; // R1
        end
      end
      default: lock_next = orr_pkg::ORR_OPEN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lock_reg <= orr_pkg::ORR_OPEN;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // Message and pending pipeline next values
  always_comb begin
    msg_next = msg_reg;
    pend_next = pend_reg;
    if (end_of_interrupt_reset) begin
      msg_next = (pend_reg | rise_vec) & ~in_mode_ch; // R4
      pend_next = orr_pkg::RST_CHAN;
    end else if (locked) begin
      pend_next = (pend_reg | rise_vec) & ~in_mode_ch; // R2
    end else begin
      msg_next = ((msg_reg & ~en_rise) | rise_vec) & ~in_mode_ch; // R5 R7
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      msg_reg <= orr_pkg::RST_CHAN;
      pend_reg <= orr_pkg::RST_CHAN;
    end else begin
      msg_reg <= msg_next;
      pend_reg <= pend_next;
    end
  end

  // Interrupt pin: messages, pending and other flags only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_pin_n_o <= 1'b1;
    end else begin
      irq_pin_n_o <= !((|msg_next) || (|pend_next)
                       || (|other_irq_flags_i)); // R3 R8
    end
  end

  // Software written controls
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      overcurrent_irq_enable <= orr_pkg::RST_CHAN;
      io_input_mode_o <= orr_pkg::RST_IO_MODE[BLOCKS-1:0];
      conv_config_o <= orr_pkg::RST_BYTE;
      mask_reg <= orr_pkg::RST_EVT;
    end else if (wr_acc) begin
      unique case (idx)
        orr_pkg::IDX_OC_EN_LOW: overcurrent_irq_enable[7:0] <= pwdata_i[7:0];
        orr_pkg::IDX_OC_EN_HIGH:
          overcurrent_irq_enable[15:8] <= pwdata_i[7:0];
        orr_pkg::IDX_IO_MODE: io_input_mode_o <= pwdata_i[BLOCKS-1:0];
        orr_pkg::IDX_CONV_CFG: conv_config_o <= pwdata_i[7:0]; // R11
        orr_pkg::IDX_EVT_MASK: mask_reg <= pwdata_i[orr_pkg::EVT_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Conversion result capture
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      conv_reg <= orr_pkg::RST_CONV;
    end else if (conv_done_i) begin
      conv_reg <= conv_result_i; // R10
    end
  end

  // Sticky events; a read clears only what it returned, set wins
  assign evt_set[orr_pkg::EVT_NEW_MSG] = (|rise_vec) && !locked;
  assign evt_set[orr_pkg::EVT_TRAPPED] = (|rise_vec) && locked;
  assign evt_set[orr_pkg::EVT_CONV_DONE] = conv_done_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      evt_reg <= orr_pkg::RST_EVT;
    end else if (rd_acc && idx == orr_pkg::IDX_EVT_STATUS) begin
      evt_reg <= (evt_reg & ~prdata_o[orr_pkg::EVT_BITS-1:0]) | evt_set;
    end else begin
      evt_reg <= evt_reg | evt_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(evt_reg & mask_reg);
    end
  end

  // Read mux, evaluated in the setup cycle
  always_comb begin
    rdata_next = orr_pkg::RST_WORD;
    mapped = 1'b1;
    unique case (idx)
      orr_pkg::IDX_MSG_LOW: rdata_next[7:0] = msg_reg[7:0] & ~in_mode_ch[7:0];
      orr_pkg::IDX_MSG_HIGH:
        rdata_next[7:0] = msg_reg[15:8] & ~in_mode_ch[15:8]; // R6
      orr_pkg::IDX_LIVE_LOW: rdata_next[7:0] = oc_live_vec[7:0]; // R8
      orr_pkg::IDX_LIVE_HIGH: rdata_next[7:0] = oc_live_vec[15:8];
      orr_pkg::IDX_CONV_UPPER:
        rdata_next[7:0] = conv_reg[orr_pkg::CONV_UPPER_MSB:
                                   orr_pkg::CONV_UPPER_LSB]; // R10 R12
      orr_pkg::IDX_CONV_LOWER:
        rdata_next[7:orr_pkg::CONV_LOWER_POS] =
          conv_reg[orr_pkg::CONV_UPPER_LSB-1:0]; // R12
      orr_pkg::IDX_OC_EN_LOW: rdata_next[7:0] = overcurrent_irq_enable[7:0];
      orr_pkg::IDX_OC_EN_HIGH: rdata_next[7:0] = overcurrent_irq_enable[15:8];
      orr_pkg::IDX_IO_MODE: rdata_next[BLOCKS-1:0] = io_input_mode_o;
      orr_pkg::IDX_EOI: rdata_next[0] = locked;
      orr_pkg::IDX_EVT_STATUS:
        rdata_next[orr_pkg::EVT_BITS-1:0] = evt_reg | evt_set;
      orr_pkg::IDX_EVT_MASK: rdata_next[orr_pkg::EVT_BITS-1:0] = mask_reg;
      orr_pkg::IDX_CONV_CFG: rdata_next[7:0] = conv_config_o;
      default: mapped = 1'b0;
    endcase
    if (paddr_i[11:orr_pkg::ADDR_IDX_MSB+1] != 2'b00) begin
      mapped = 1'b0;
      rdata_next = orr_pkg::RST_WORD;
    end
  end

  // APB answer: one access cycle after every setup
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= orr_pkg::RST_WORD;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= !mapped;
      prdata_o <= pwrite_i ? orr_pkg::RST_WORD : rdata_next;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_read_setup(logic [7:0] i);
    psel_i && !penable_i && !pwrite_i && idx == i
    && paddr_i[11:orr_pkg::ADDR_IDX_MSB+1] == 2'b00;
  endsequence

  a_lock_on_read: assert property ( // R1
    rd_acc && irq_active && !locked && idx == orr_pkg::IDX_MSG_LOW
    |=> locked)
    else $error("message read with active interrupt did not lock");

  a_lock_holds_msg: assert property ( // R1
    locked && !end_of_interrupt_reset |=> $stable(msg_reg))
    else $error("messages changed while locked");

  a_pending_trap: assert property ( // R2
    locked && !end_of_interrupt_reset && (|rise_vec)
    |=> (pend_reg & $past(rise_vec)) == $past(rise_vec))
    else $error("event while locked not trapped");

  a_irq_stays_low: assert property ( // R3
    end_of_interrupt_reset && (|pend_reg) |=> !irq_pin_n_o [*2])
    else $error("interrupt pin released with pending events");

  a_eoi_reload: assert property ( // R4
    end_of_interrupt_reset && ((pend_reg & in_mode_ch) == 0)
    |=> msg_reg == ($past(pend_reg) | $past(rise_vec)) && pend_reg == 0)
    else $error("end of interrupt did not reload messages");

  a_latch_enabled: assert property ( // R5
    !locked && (|rise_vec)
    |=> (msg_reg & $past(rise_vec)) == $past(rise_vec))
    else $error("enabled overcurrent not latched");

  a_input_reads_zero: assert property ( // R6
    s_read_setup(orr_pkg::IDX_MSG_LOW)
    |=> (prdata_o[7:0] & $past(in_mode_ch[7:0])) == 8'h00)
    else $error("input channel message not zero");

  a_reenable_clears: assert property ( // R7
    !locked && !end_of_interrupt_reset
    |=> ($past(en_rise) & ~$past(rise_vec) & msg_reg) == 0)
    else $error("re-enable did not clear message");

  a_live_no_irq: assert property ( // R8
    msg_next == 0 && pend_next == 0 && other_irq_flags_i == 0
    |=> irq_pin_n_o)
    else $error("interrupt pin asserted without a message");

  a_live_readout: assert property ( // R9
    s_read_setup(orr_pkg::IDX_LIVE_LOW)
    |=> prdata_o[7:0] == $past(oc_live_vec[7:0]) && pready_o)
    else $error("live status readout wrong");

  a_conv_split: assert property ( // R12
    s_read_setup(orr_pkg::IDX_CONV_LOWER)
    |=> prdata_o == {24'h00_0000, $past(conv_reg[1:0]), 6'h00})
    else $error("conversion lower register layout wrong");

  a_conv_config: assert property ( // R11
    wr_acc && idx == orr_pkg::IDX_CONV_CFG
    |=> conv_config_o == $past(pwdata_i[7:0]))
    else $error("configuration word not stored");

endmodule

// ===== verification/orr_apb_host.sv
// APB host model standing in for the microcontroller
`timescale 1ns/1ps
module orr_apb_host (
  // Clock
  input wire logic clk_i,
  // APB master signals
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic pready_i
);
  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // One transfer: setup, then access held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= {2'b00, idx, 2'b00};
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d; // Stale data is not left on the bus
  endtask
endmodule

// ===== verification/tb_orr_top.sv
// Self-checking testbench for the overcurrent report registers
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_orr_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel, penable, pwrite, pready_o, pslverr_o, conv_done = 1'b0;
  logic irq_pin_n_o, irq_o;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_o;
  logic [15:0] oc_pin = 16'h0000;
  logic [6:0] other_irq = 7'h00;
  logic [9:0] conv_res = 10'h000;
  logic [9:0] r;
  logic [7:0] conv_config_o;
  logic [3:0] io_input_mode_o;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  integer seed = 32'hdcdb;
  int failures = 0;
  int num_checks = 0;

  // Clock
  always #2 clk_i = ~clk_i;

  orr_apb_host i_host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .pready_i(pready_o));

  orr_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .oc_live_pin_i(oc_pin),
    .other_irq_flags_i(other_irq), .conv_result_i(conv_res),
    .conv_done_i(conv_done), .conv_config_o(conv_config_o),
    .io_input_mode_o(io_input_mode_o), .irq_pin_n_o(irq_pin_n_o),
    .irq_o(irq_o));

  // Read results compared against the oldest expectation
  always @(posedge clk_i) begin
    if (psel && penable && pready_o && !pwrite) begin
      e = exp_q.pop_front();
      `CHK({pslverr_o, prdata_o}, e)
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    i_host.xfer(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [32:0] x);
    exp_q.push_back(x);
    i_host.xfer(1'b0, idx, 32'h0000_0000);
  endtask

  // Drive one overcurrent pin, then let the synchroniser settle
  task automatic pin(input int ch, input logic v);
    @(posedge clk_i);
    oc_pin[ch] <= v;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic complete_run;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Reset values, unmapped index, read-only write
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0000);
    rd(orr_pkg::IDX_CONV_UPPER, 33'h0_0000_0000);
    rd(8'h30, 33'h1_0000_0000);
    wr(orr_pkg::IDX_MSG_LOW, 32'h0000_00ff);
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0000);
    // Conversion results and the done interrupt
    wr(orr_pkg::IDX_EVT_MASK, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      wr(orr_pkg::IDX_CONV_CFG, {24'h00_0000, r[9:2]});
      @(posedge clk_i);
      `CHK(conv_config_o, r[9:2])
      conv_res <= r;
      conv_done <= 1'b1;
      @(posedge clk_i);
      conv_done <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      rd(orr_pkg::IDX_CONV_UPPER, {25'h0, r[9:2]});
      rd(orr_pkg::IDX_CONV_LOWER, {25'h0, r[1:0], 6'h00});
      rd(orr_pkg::IDX_EVT_STATUS, 33'h0_0000_0004);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
    end
    // Latch, lock, pending pipeline and end of interrupt
    wr(orr_pkg::IDX_OC_EN_LOW, 32'h0000_00ff);
    pin(0, 1'b1);
    `CHK(irq_pin_n_o, 1'b0)
    rd(orr_pkg::IDX_LIVE_LOW, 33'h0_0000_0001);
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0001);
    pin(1, 1'b1);
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0001);
    wr(orr_pkg::IDX_EOI, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b0)
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0002);
    wr(orr_pkg::IDX_EOI, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b1)
    // Disabled channel: live only, no interrupt
    wr(orr_pkg::IDX_OC_EN_LOW, 32'h0000_00fb);
    pin(2, 1'b1);
    `CHK(irq_pin_n_o, 1'b1)
    rd(orr_pkg::IDX_LIVE_LOW, 33'h0_0000_0007);
    // Clearing a message by disable then re-enable
    wr(orr_pkg::IDX_OC_EN_LOW, 32'h0000_00ff);
    pin(3, 1'b1);
    `CHK(irq_pin_n_o, 1'b0)
    wr(orr_pkg::IDX_OC_EN_LOW, 32'h0000_00f7);
    wr(orr_pkg::IDX_OC_EN_LOW, 32'h0000_00ff);
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b1)
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0000);
    // Input mode hides message and live bits
    wr(orr_pkg::IDX_OC_EN_HIGH, 32'h0000_00ff);
    pin(12, 1'b1);
    rd(orr_pkg::IDX_LIVE_HIGH, 33'h0_0000_0010);
    wr(orr_pkg::IDX_IO_MODE, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    `CHK(io_input_mode_o, 4'h8)
    rd(orr_pkg::IDX_MSG_HIGH, 33'h0_0000_0000);
    rd(orr_pkg::IDX_LIVE_HIGH, 33'h0_0000_0000);
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b1)
    // Sticky events: unlocked latches and one trapped while locked
    rd(orr_pkg::IDX_EVT_STATUS, 33'h0_0000_0003);
    rd(orr_pkg::IDX_EVT_STATUS, 33'h0_0000_0000);
    // Another interrupt source alone locks on a message read
    other_irq <= 7'h01;
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b0)
    rd(orr_pkg::IDX_MSG_LOW, 33'h0_0000_0000);
    rd(orr_pkg::IDX_EOI, 33'h0_0000_0001);
    wr(orr_pkg::IDX_EOI, 32'h0000_0000);
    rd(orr_pkg::IDX_EOI, 33'h0_0000_0000);
    other_irq <= 7'h00;
    repeat (2) @(posedge clk_i);
    `CHK(irq_pin_n_o, 1'b1)
    complete_run();
  end
endmodule
